// *** hw/cvd_seq_map.svh ***
// Register offsets, field positions, reset values and timing counts of the CVD sequencer
`ifndef CVD_SEQ_MAP_SVH
`define CVD_SEQ_MAP_SVH
`define CVD_IDX_CTRL   4'h0
`define CVD_IDX_PRE    4'h1
`define CVD_IDX_ACQ    4'h2
`define CVD_IDX_CAP    4'h3
`define CVD_IDX_RPT    4'h4
`define CVD_IDX_THR    4'h5
`define CVD_IDX_STAT   4'h6
`define CVD_IDX_CNT    4'h7
`define CVD_IDX_ACC    4'h8
`define CVD_IDX_FLT    4'h9
`define CVD_IDX_RES    4'hA
`define CVD_CTRL_GO    0
`define CVD_CTRL_CLR   1
`define CVD_CTRL_LSB   2
`define CVD_CTRL_MSB   11
`define CVD_STAT_DONE  0
`define CVD_STAT_THR   1
`define CVD_RST_CTRL   10'h000
`define CVD_RST_BYTE   8'h00
`define CVD_RST_CAP    5'h00
`define CVD_RST_THR    16'hFFFF
`define CVD_ACQ_MAX    9'h100
`endif

// *** hw/cvd_seq_pkg.sv ***
// Types shared by the CVD sequencer
package cvd_seq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PRE  = 2'b01,
    ST_ACQ  = 2'b10,
    ST_CONV = 2'b11
  } stage_t;
  typedef enum logic [2:0] {
    MD_BASIC = 3'b000,
    MD_ACCUM = 3'b001,
    MD_AVG   = 3'b010,
    MD_BURST = 3'b011,
    MD_LPF   = 3'b100
  } mode_t;
  typedef struct packed {
    logic [2:0] shift;
    logic [2:0] computation_mode;
    logic       double_sample_enable;
    logic       guard_invert_enable;
    logic       guard_polarity;
    logic       precharge_polarity;
  } ctrl_t;
  typedef struct packed {
    logic hold_isolate;
    logic hold_level;
    logic pin_override;
    logic pin_level;
    logic sample_connect;
  } analog_t;
endpackage

// *** hw/cvd_seq.sv ***
// CVD precharge/acquisition sequencer with post-conversion computation
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "cvd_seq_map.svh"
module cvd_seq import cvd_seq_pkg::*; #(
  parameter int RES_W = 10,
  parameter int ACC_W = 16
) (
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             rst_in,
  // Register port
  input  wire logic [3:0]       addr_in,
  input  wire logic [15:0]      wdata_in,
  input  wire logic             wr_in,
  input  wire logic             rd_in,
  output logic      [15:0]      rdata_out,
  // Converter core
  input  wire logic             trigger_in,
  input  wire logic             conv_done_in,
  input  wire logic [RES_W-1:0] result_in,
  output logic                  conv_start_out,
  output logic                  busy_out,
  // Analog switches
  output logic                  hold_isolate_out,
  output logic                  hold_level_out,
  output logic                  sample_connect_out,
  output logic      [4:0]       extra_sample_cap_out,
  // Channel pin
  input  wire logic             pin_direction_in,
  input  wire logic             port_data_in,
  output logic                  pin_o_out,
  output logic                  pin_oe_out,
  // Guard rings
  output logic                  guard_out_a,
  output logic                  guard_out_b
);
  if (RES_W < 1 || RES_W > ACC_W || ACC_W > 16) begin : g_chk
    $error("cvd_seq: unsupported widths");
  end

  // ==========================================================
  // Registers
  ctrl_t            ctrl_q;
  logic [7:0]       pre_q, acq_q, rpt_q, cnt_q, cnt_d;
  logic [4:0]       cap_q;
  logic [15:0]      thr_q, rdata_q;
  logic [ACC_W-1:0] acc_q, acc_d, flt_q, flt_d;
  logic [RES_W-1:0] s1_q, res_q;
  logic             done_q, tflag_q, second_q, second_d;
  stage_t           state_q, state_d;
  logic [8:0]       tcnt_q, tcnt_d, age_q;
  analog_t          ana_q, ana_d;
  logic [4:0]       cap_out_q;
  logic             conv_start_q, busy_q, pin_o_q, pin_oe_q, ga_q, gb_q;

  // ==========================================================
  // Bus decode
  wire        wr_ctrl  = wr_in && addr_in == `CVD_IDX_CTRL;
  wire        wr_stat  = wr_in && addr_in == `CVD_IDX_STAT;
  wire        go_wr    = wr_ctrl && wdata_in[`CVD_CTRL_GO];
  wire        clr_wr   = wr_ctrl && wdata_in[`CVD_CTRL_CLR];
  wire        idle     = state_q == ST_IDLE;
  wire [15:0] rd_mux   =
    addr_in == `CVD_IDX_CTRL ? {4'h0, ctrl_q, 1'b0, !idle} :
    addr_in == `CVD_IDX_PRE  ? {8'h00, pre_q} :
    addr_in == `CVD_IDX_ACQ  ? {8'h00, acq_q} :
    addr_in == `CVD_IDX_CAP  ? {11'h000, cap_q} :
    addr_in == `CVD_IDX_RPT  ? {8'h00, rpt_q} :
    addr_in == `CVD_IDX_THR  ? thr_q :
    addr_in == `CVD_IDX_STAT ? {12'h000, state_q, tflag_q, done_q} :
    addr_in == `CVD_IDX_CNT  ? {8'h00, cnt_q} :
    addr_in == `CVD_IDX_ACC  ? 16'(acc_q) :
    addr_in == `CVD_IDX_FLT  ? 16'(flt_q) :
    addr_in == `CVD_IDX_RES  ? 16'(res_q) : 16'h0000;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ctrl_q  <= ctrl_t'(`CVD_RST_CTRL);
      pre_q   <= `CVD_RST_BYTE;
      acq_q   <= `CVD_RST_BYTE;
      rpt_q   <= `CVD_RST_BYTE;
      cap_q   <= `CVD_RST_CAP;
      thr_q   <= `CVD_RST_THR;
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rd_in ? rd_mux : 16'h0000;
      if (wr_ctrl) ctrl_q <= ctrl_t'(wdata_in[`CVD_CTRL_MSB:`CVD_CTRL_LSB]);
      if (wr_in && addr_in == `CVD_IDX_PRE) pre_q <= wdata_in[7:0];
      if (wr_in && addr_in == `CVD_IDX_ACQ) acq_q <= wdata_in[7:0];
      if (wr_in && addr_in == `CVD_IDX_RPT) rpt_q <= wdata_in[7:0];
      if (wr_in && addr_in == `CVD_IDX_CAP) cap_q <= wdata_in[4:0];
      if (wr_in && addr_in == `CVD_IDX_THR) thr_q <= wdata_in;
    end
  end

  // ==========================================================
  // Stage sequencer
  // Triggers during a conversion are dropped; the core cannot queue them
  wire       start     = idle && (go_wr || trigger_in);
  wire       pre_on    = pre_q != 8'h00;
  wire [8:0] acq_len   = (acq_q == 8'h00) ? `CVD_ACQ_MAX : {1'b0, acq_q};
  wire       conv_end  = state_q == ST_CONV && conv_done_in;
  wire       need_2nd  = ctrl_q.double_sample_enable && !second_q;
  wire       complete  = conv_end && !need_2nd;
  wire       expire    = tcnt_q == 9'h001;
  mode_t     mode;
  logic      restart, start_ev, acq_begin;
  stage_t    entry;
  logic [8:0] entry_len;

  assign mode     = mode_t'(ctrl_q.computation_mode);
  assign start_ev = start || (conv_end && (need_2nd || restart));

  // Entry stage for any new sample
  always_comb begin
    entry     = ST_CONV;
    entry_len = 9'h000;
    if (pre_on) begin
      entry     = ST_PRE;
      entry_len = {1'b0, pre_q};
    end else if (acq_q != 8'h00) begin
      entry     = ST_ACQ;
      entry_len = {1'b0, acq_q};
    end
  end

  always_comb begin
    state_d  = state_q;
    tcnt_d   = (tcnt_q == 9'h000) ? tcnt_q : tcnt_q - 9'h001;
    second_d = second_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start) begin
          state_d  = entry;
          tcnt_d   = entry_len;
          second_d = 1'b0;
        end
      end
      ST_PRE: begin
        if (expire) begin
          state_d = ST_ACQ;
          tcnt_d  = acq_len;
        end
      end
      ST_ACQ: begin
        if (expire) state_d = ST_CONV;
      end
      ST_CONV: begin
        if (conv_done_in) begin
          if (start_ev) begin
            state_d  = entry;
            tcnt_d   = entry_len;
            second_d = need_2nd;
          end else begin
            state_d  = ST_IDLE;
          end
        end
      end
    endcase
  end

  assign acq_begin = (state_d == ST_ACQ && state_q != ST_ACQ) || (start_ev && state_d == ST_CONV);

  // ==========================================================
  // Analog and pin controls, registered from the next stage
  wire hold_lvl  = ctrl_q.precharge_polarity ^ second_d;
  wire guard_lvl = second_d && ctrl_q.guard_invert_enable ? !ctrl_q.guard_polarity
                                                          : ctrl_q.guard_polarity;
  always_comb begin
    ana_d.hold_isolate   = state_d == ST_PRE;
    ana_d.hold_level     = hold_lvl;
    ana_d.pin_override   = state_d == ST_PRE;
    ana_d.pin_level      = !hold_lvl;
    ana_d.sample_connect = state_d == ST_ACQ || state_d == ST_IDLE;
  end
  wire ga_base = start_ev ? guard_lvl : ga_q;
  wire gb_d    = start_ev ? guard_lvl : gb_q;
  wire ga_d    = ga_base ^ acq_begin;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_q      <= ST_IDLE;
      tcnt_q       <= 9'h000;
      second_q     <= 1'b0;
      ana_q        <= '0;
      cap_out_q    <= 5'h00;
      conv_start_q <= 1'b0;
      busy_q       <= 1'b0;
      pin_o_q      <= 1'b0;
      pin_oe_q     <= 1'b0;
      ga_q         <= 1'b0;
      gb_q         <= 1'b0;
    end else begin
      state_q      <= state_d;
      tcnt_q       <= tcnt_d;
      second_q     <= second_d;
      ana_q        <= ana_d;
      cap_out_q    <= (state_d == ST_CONV) ? 5'h00 : cap_q;
      conv_start_q <= state_d == ST_CONV && (state_q != ST_CONV || start_ev);
      busy_q       <= state_d != ST_IDLE;
      pin_o_q      <= ana_d.pin_override ? ana_d.pin_level : port_data_in;
      // Normal drive is also cut in acquisition, so the port cannot spoil the charge share
      pin_oe_q     <= ana_d.pin_override || (!pin_direction_in && state_d != ST_ACQ);
      ga_q         <= ga_d;
      gb_q         <= gb_d;
    end
  end

  // ==========================================================
  // Computation
  wire              trig_clr = start && (mode == MD_BURST || (mode == MD_AVG && cnt_q >= rpt_q));
  wire [ACC_W-1:0]  samp     = ctrl_q.double_sample_enable
                               ? ACC_W'(result_in) - ACC_W'(s1_q) : ACC_W'(result_in);
  wire [ACC_W-1:0]  acc_base = (clr_wr || trig_clr) ? '0 : acc_q;
  wire [7:0]        cnt_base = (clr_wr || trig_clr) ? 8'h00 : cnt_q;
  wire [7:0]        cnt_inc  = (cnt_base == 8'hFF) ? cnt_base : cnt_base + 8'h01;
  logic             test;

  // Modes 5..7 behave as basic
  always_comb begin
    acc_d = acc_base;
    cnt_d = cnt_base;
    flt_d = flt_q;
    test  = 1'b0;
    if (complete) begin
      unique case (mode)
        MD_ACCUM, MD_AVG, MD_BURST: begin
          acc_d = acc_base + samp;
          cnt_d = cnt_inc;
          flt_d = acc_d >> ctrl_q.shift;
          test  = (mode == MD_ACCUM) || cnt_d >= rpt_q;
        end
        MD_LPF: begin
          acc_d = acc_base + samp - (acc_base >> ctrl_q.shift);
          cnt_d = cnt_inc;
          flt_d = acc_d >> ctrl_q.shift;
          test  = cnt_d >= rpt_q;
        end
        default: begin
          flt_d = samp;
          test  = 1'b1;
        end
      endcase
    end
  end
  assign restart = complete && mode == MD_BURST && cnt_d < rpt_q;

  // Status flags: a hardware set wins over a software clear in the same cycle
  wire thr_hit = test && (16'(flt_d) > thr_q);
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      acc_q   <= '0;
      cnt_q   <= 8'h00;
      flt_q   <= '0;
      s1_q    <= '0;
      res_q   <= '0;
      done_q  <= 1'b0;
      tflag_q <= 1'b0;
    end else begin
      acc_q   <= acc_d;
      cnt_q   <= cnt_d;
      flt_q   <= flt_d;
      if (conv_end && need_2nd) s1_q <= result_in;
      if (conv_end) res_q <= result_in;
      done_q  <= complete || (done_q && !(wr_stat && wdata_in[`CVD_STAT_DONE]));
      tflag_q <= thr_hit || (tflag_q && !(wr_stat && wdata_in[`CVD_STAT_THR]));
    end
  end

  // ==========================================================
  // Outputs
  assign rdata_out            = rdata_q;
  assign conv_start_out       = conv_start_q;
  assign busy_out             = busy_q;
  assign hold_isolate_out     = ana_q.hold_isolate;
  assign hold_level_out       = ana_q.hold_level;
  assign sample_connect_out   = ana_q.sample_connect;
  assign extra_sample_cap_out = cap_out_q;
  assign pin_o_out            = pin_o_q;
  assign pin_oe_out           = pin_oe_q;
  assign guard_out_a          = ga_q;
  assign guard_out_b          = gb_q;

  // ==========================================================
  // Checks
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || state_d != state_q || start_ev) age_q <= 9'h000;
    else age_q <= age_q + 9'h001;
  end

  a_pre_skip: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    start && !pre_on |=> state_q != ST_PRE) else $error("precharge not skipped");
  a_pre_entry: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    start_ev && pre_on |=> state_q == ST_PRE && hold_isolate_out) else $error("no precharge at start");
  a_pin_opposite: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    state_q == ST_PRE |-> pin_oe_out && pin_o_out != hold_level_out) else $error("pin not driven opposite");
  a_pre_length: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    state_q == ST_PRE && state_d == ST_ACQ |-> age_q + 9'h001 == {1'b0, pre_q}) else $error("precharge length");
  a_acq_max: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    state_q == ST_ACQ && state_d == ST_CONV && pre_on && acq_q == 8'h00 |-> age_q == 9'h0FF)
    else $error("acquisition not 256");
  a_no_hw_acq: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    start && !pre_on && acq_q == 8'h00 |=> state_q == ST_CONV ##0 conv_start_out) else $error("acq timed");
  a_guard_first: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    start && pre_on |=> guard_out_a == ctrl_q.guard_polarity && guard_out_b == ctrl_q.guard_polarity)
    else $error("guard start level");
  a_guard_acq: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    state_q == ST_PRE && state_d == ST_ACQ |=> guard_out_a != $past(guard_out_a)
    && guard_out_b == $past(guard_out_b)) else $error("guard acq edge");
  a_cap_conv: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    state_q == ST_CONV |-> extra_sample_cap_out == 5'h00) else $error("cap during conversion");
  a_done_set: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    complete |=> done_q ##1 rdata_out[`CVD_STAT_DONE] || !$past(rd_in && addr_in == `CVD_IDX_STAT))
    else $error("done flag not set");
  a_burst_more: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    restart && pre_on |=> state_q == ST_PRE) else $error("burst not repeated");

  c_double: cover property (@(posedge ref_clk_in) disable iff (rst_in) complete && second_q);
  c_burst: cover property (@(posedge ref_clk_in) disable iff (rst_in) restart);
  c_lpf_thr: cover property (@(posedge ref_clk_in) disable iff (rst_in) thr_hit && mode == MD_LPF);
endmodule
`default_nettype wire

// *** tb/cvd_sensor_model.sv ***
// Capacitive sensor electrode and shared hold node model
`timescale 1ns/1ps
`default_nettype none
// ==========
// Sensor electrode
module cvd_sensor_model (
  // Clock
  input  wire logic       ref_clk_in,
  // Pin and hold switches
  input  wire logic       pin_o_in,
  input  wire logic       pin_oe_in,
  input  wire logic       isolate_in,
  input  wire logic       connect_in,
  input  wire logic       hold_level_in,
  // Voltage seen by the converter
  output logic      [9:0] level_out
);
  logic       charge_q;
  logic [9:0] hold_q;
  // Hold node keeps its charge while switched off, as the real capacitor does
  always_ff @(posedge ref_clk_in) begin
    if (pin_oe_in) begin
      charge_q <= pin_o_in;
    end
    if (isolate_in) begin
      hold_q <= {10{hold_level_in}};
    end else if (connect_in) begin
      hold_q <= (charge_q == hold_q[9]) ? hold_q : 10'h1FF;
    end
  end
  assign level_out = hold_q;
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking testbench for the CVD sequencer
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench
module tb import cvd_seq_pkg::*;;
  logic        ref_clk_in, rst_in, wr_in, rd_in, trigger_in, conv_done_in;
  logic        pin_direction_in, port_data_in, use_sensor;
  logic [3:0]  addr_in;
  logic [15:0] wdata_in, rdata_out, ctl, thr_v, acc_m, flt_m;
  logic [9:0]  result_in, sense, last_r;
  logic        conv_start_out, busy_out, hold_isolate_out, hold_level_out, sample_connect_out;
  logic        pin_o_out, pin_oe_out, guard_out_a, guard_out_b, thr_m;
  logic [4:0]  extra_sample_cap_out, cap;
  logic [7:0]  pre, acq, rpt_v, cnt_m;
  int          fail_count, cmp_count, passes;
  logic [15:0] samp_q[$];
  cvd_seq i_cvd_seq (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .trigger_in(trigger_in), .conv_done_in(conv_done_in),
    .result_in(result_in), .conv_start_out(conv_start_out), .busy_out(busy_out),
    .hold_isolate_out(hold_isolate_out), .hold_level_out(hold_level_out), .sample_connect_out(sample_connect_out),
    .extra_sample_cap_out(extra_sample_cap_out), .pin_direction_in(pin_direction_in),
    .port_data_in(port_data_in), .pin_o_out(pin_o_out), .pin_oe_out(pin_oe_out),
    .guard_out_a(guard_out_a), .guard_out_b(guard_out_b));
  cvd_sensor_model i_cvd_sensor_model (.ref_clk_in(ref_clk_in), .pin_o_in(pin_o_out), .pin_oe_in(pin_oe_out),
    .isolate_in(hold_isolate_out), .connect_in(sample_connect_out), .hold_level_in(hold_level_out),
    .level_out(sense));
  // ==========
  // Compare, bus and closing tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t level %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, e);
    @(posedge ref_clk_in);
    #1 chk(rdata_out, 16'h0000);
  endtask
  task automatic results();
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========
  // One full sequence, watched cycle by cycle
  task automatic seq(input logic trig);
    int   k, np, nc, pc, ac;
    logic iso_p, con_p, ga_p, gb_p, sec;
    np    = 0;
    nc    = 0;
    pc    = 0;
    ac    = 0;
    iso_p = 1'b0;
    con_p = 1'b1;
    if (trig) begin
      @(posedge ref_clk_in);
      trigger_in <= 1'b1;
      @(posedge ref_clk_in);
      trigger_in <= 1'b0;
    end else begin
      wr(4'h0, ctl | 16'h0001);
    end
    for (k = 0; k < 3000 && (k < 2 || busy_out !== 1'b0); k++) begin
      if (k != 0) trigger_in <= (k == 2);
      #1;
      sec = ctl[5] && np[0];
      if (hold_isolate_out && !iso_p) begin
        np++;
        chk1(hold_level_out, ctl[2] ^ sec);
        chk1(guard_out_a, ctl[3] ^ (sec && ctl[4]));
        chk1(guard_out_b, ctl[3] ^ (sec && ctl[4]));
        pc = 0;
      end
      if (hold_isolate_out) begin
        pc++;
        chk1(pin_oe_out, 1'b1);
        chk1(pin_o_out, !hold_level_out);
        chk1(sample_connect_out, 1'b0);
      end
      if (!hold_isolate_out && iso_p) chk(16'(pc), {8'h00, pre});
      if (busy_out && sample_connect_out && !hold_isolate_out) begin
        ac++;
        chk1(pin_oe_out, 1'b0);
        chk({11'h000, extra_sample_cap_out}, {11'h000, cap});
      end else if (!hold_isolate_out) begin
        chk1(pin_oe_out, !pin_direction_in);
        chk1(pin_o_out, port_data_in);
      end
      if (busy_out && sample_connect_out && !con_p && pre != 0) begin
        chk1(guard_out_a, !ga_p);
        chk1(guard_out_b, gb_p);
      end
      if (conv_start_out) begin
        nc++;
        chk(16'(ac), acq != 0 ? {8'h00, acq} : (pre != 0 ? 16'h0100 : 16'h0000));
        chk({11'h000, extra_sample_cap_out}, 16'h0000);
        ac = 0;
      end
      {iso_p, con_p, ga_p, gb_p} = {hold_isolate_out, sample_connect_out, guard_out_a, guard_out_b};
      @(posedge ref_clk_in);
    end
    chk1(busy_out, 1'b0);
    chk(16'(nc), 16'(passes));
    chk(16'(np), pre != 0 ? 16'(passes) : 16'h0000);
  endtask
  // ==========
  // Expected computation result per sample
  function automatic void step(input logic [2:0] md, input logic [15:0] s);
    if (md == MD_BASIC || md > MD_LPF) begin
      flt_m = s;
    end else begin
      acc_m = (md == MD_LPF) ? acc_m + s - (acc_m >> ctl[11:9]) : acc_m + s;
      cnt_m = (cnt_m == 8'hFF) ? cnt_m : cnt_m + 8'h01;
      flt_m = acc_m >> ctl[11:9];
    end
    if ((md < MD_AVG || md > MD_LPF || cnt_m >= rpt_v) && flt_m > thr_v) thr_m = 1'b1;
  endfunction
  // ==========
  // Converter core stand-in
  initial begin
    logic [9:0] r;
    conv_done_in = 1'b0;
    result_in    = 10'h000;
    forever begin
      @(posedge ref_clk_in);
      if (conv_start_out === 1'b1) begin
        repeat (2) @(posedge ref_clk_in);
        r = use_sensor ? sense : 10'($urandom);
        if (use_sensor) chk({6'h00, r}, 16'h01FF);
        conv_done_in <= 1'b1;
        result_in    <= r;
        last_r       = r;
        samp_q.push_back({6'h00, r});
        @(posedge ref_clk_in);
        conv_done_in <= 1'b0;
      end
    end
  end
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    repeat (40000) @(posedge ref_clk_in);
    fail_count++;
    results();
  end
  // ==========
  // Main sequence
  initial begin
    int         i;
    logic [2:0] md;
    logic [15:0] s;
    {rst_in, pin_direction_in} = 2'b11;
    {wr_in, rd_in, trigger_in, port_data_in, use_sensor} = 5'h00;
    {addr_in, wdata_in, acc_m, cnt_m, flt_m} = '0;
    fail_count = 0;
    cmp_count  = 0;
    void'($urandom(32'hA56E));
    repeat (20) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    for (i = 0; i < 8; i++) rc(4'(i), i == 5 ? 16'hFFFF : 16'h0000);
    rc(4'hB, 16'h0000);
    for (i = 0; i < 40; i++) begin
      md       = 3'(i % 8);
      pre      = (i == 0) ? 8'h03 : ((i == 1) ? 8'h00 : 8'($urandom % 4));
      acq      = (i < 2) ? 8'h00 : 8'($urandom % 5);
      ctl      = 16'($urandom) & 16'h003C;
      ctl[5]   = ctl[5] && (md == MD_BASIC);
      ctl[8:6] = md;
      ctl[11:9] = 3'($urandom);
      cap      = 5'($urandom);
      rpt_v    = 8'($urandom % 3 + 1);
      thr_v    = 16'($urandom % 1024);
      passes   = (md == MD_BURST) ? rpt_v : (ctl[5] ? 2 : 1);
      use_sensor = (pre != 0);
      @(posedge ref_clk_in);
      port_data_in     <= 1'($urandom);
      pin_direction_in <= 1'($urandom);
      thr_m = 1'b0;
      if (md == MD_BURST || (md == MD_AVG && cnt_m >= rpt_v) || i % 10 == 7) {acc_m, cnt_m} = '0;
      if (i % 10 == 7) wr(4'h0, 16'h0002);
      wr(4'h0, ctl);
      wr(4'h1, {8'h00, pre});
      wr(4'h2, {8'h00, acq});
      wr(4'h3, {11'h000, cap});
      wr(4'h4, {8'h00, rpt_v});
      wr(4'h5, thr_v);
      wr(4'h6, 16'h0003);
      seq(i[0]);
      while (samp_q.size() > 0) begin
        s = samp_q.pop_front();
        if (ctl[5]) s = samp_q.pop_front() - s;
        step(md, s);
      end
      rc(4'h6, {14'h0000, thr_m, 1'b1});
      rc(4'h7, {8'h00, cnt_m});
      rc(4'h8, acc_m);
      rc(4'h9, flt_m);
      rc(4'hA, {6'h00, last_r});
    end
    results();
  end
endmodule
`default_nettype wire
